// File: hdl/scr_bank.sv
`timescale 1ns/1ps
// What this block does
// - Word is data field then two address bits, address in bits 1..0.
// - On enable rise, decode address and load data into that register only.
// - Last 16 bits shifted are committed; host sends at least 16.
// - Address 00 PLL config, 01 channel divide, 10 test mode.
// - All register bits are zero from power-up, effective immediately.
// - PLL bit 2 selects charge-pump polarity, 1 means sourcing.
// - PLL bit 3 sets reference divider: 0 divides by 9, 1 by 18.
// - PLL bit 4 picks analog pin role: 0 power control, 1 data.
// - PLL bit 6 gives unmodulated carrier while receive select is low.
// - With role 0, bit 7 set pulls open-drain pin low, clear releases.
// - Power-control pin adopts new bit only at receive-select falling edge.
// - Bit 8: 0 keeps RF buffer on in transmit, 1 follows amplifier enable.
// - With bit 10, low supply sets lockout forcing amplifier low; receive clears.
// - PLL bit 11 set disables signal-strength clipping.
// - Channel register holds 12-bit divide ratio in word bits 13..2.
// - Test register: digital selector data bits 5..3, analog 2..0.
// - Shift data on serial clock rise while enable low; ignore when high.
// - Registers are write-only; nothing reads them back over serial.
module scr_bank
  import scr_pkg::*;
#(
  parameter int WORD_BITS = WORD_W
) (
  // Clock and power-up reset
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  // Three-wire serial bus
  input wire logic SER_EN_IN,
  input wire logic SER_DATA_IN,
  input wire logic SER_CLK_IN,
  // Radio control
  input wire logic RECEIVE_SELECT_IN,
  input wire logic LOW_SUPPLY_IN,
  input wire logic AMP_REQUEST_IN,
  output logic AMP_ENABLE_OUT,
  output logic RF_BUFFER_ON_OUT,
  output logic CARRIER_ONLY_OUT,
  // Open-drain power-control pin
  input wire logic POWER_CONTROL_PIN_IN,
  output logic POWER_CONTROL_PIN_OUT,
  output logic POWER_CONTROL_PIN_OE_N_OUT,
  // PLL configuration fields
  output logic PUMP_SOURCES_OUT,
  output logic [DIV_W-1:0] REF_DIVIDE_RATIO_OUT,
  output logic ANALOG_PIN_DATA_ROLE_OUT,
  output logic STRENGTH_CLIP_ENABLE_OUT,
  output logic RF_BUFFER_TIMING_MODE_OUT,
  // Channel and test fields
  output logic [CHAN_W-1:0] CHANNEL_DIVIDE_VALUE_OUT,
  output logic [SEL_W-1:0] DIGITAL_TEST_SELECTOR_OUT,
  output logic [SEL_W-1:0] ANALOG_TEST_SELECTOR_OUT
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (WORD_BITS != WORD_W) begin : g_word_check
    $error("scr_bank: word length is fixed at 16 bits");
  end

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  scr_pins_t pin_raw;
  scr_pins_t pin_s;

  assign pin_raw.ser_en = SER_EN_IN;
  assign pin_raw.ser_data = SER_DATA_IN;
  assign pin_raw.ser_clk = SER_CLK_IN;
  assign pin_raw.receive_select = RECEIVE_SELECT_IN;
  assign pin_raw.low_supply = LOW_SUPPLY_IN;

  // Data and clock share one synchroniser so their relative timing holds
  scr_sync #(
    .WIDTH($bits(scr_pins_t))
  ) u_sync (
    .clk_in(MCLK_IN),
    .rst_in(RESET_IN),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  scr_state_t st_r;
  scr_state_t st_nxt;

  logic clk_rise;
  logic en_rise;
  logic receive_select_input_fall;
  logic [ADDR_W-1:0] word_addr;
  logic [WORD_W-1:0] word_committed;

  assign clk_rise = pin_s.ser_clk & ~st_r.clk_q;
  // Sync resets low, so an idle-high enable shows one rise after reset;
  // it commits the zero reset word into zero registers, which is harmless
  assign en_rise = pin_s.ser_en & ~st_r.en_q;
  assign receive_select_input_fall = ~pin_s.receive_select & st_r.receive_select_input_q;
  // Address is always the last two bits shifted
  assign word_addr = st_r.shift[ADDR_W-1:0];
  // Fewer than 16 fresh bits leave stale bits in the word
  assign word_committed = st_r.shift;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.en_q = pin_s.ser_en;
    st_nxt.clk_q = pin_s.ser_clk;
    st_nxt.receive_select_input_q = pin_s.receive_select;

    // MSB arrives first, so shift toward the top
    if (clk_rise && !pin_s.ser_en) begin
      st_nxt.shift = {st_r.shift[WORD_W-2:0], pin_s.ser_data};
    end

    // Load only the addressed register; registers never feed back out
    if (en_rise) begin
      unique case (word_addr)
        ADDR_PLL_CFG: begin
          st_nxt.regs.pll_configuration = word_committed;
        end
        ADDR_CHAN_DIV: begin
          st_nxt.regs.channel_divide_ratio = word_committed;
        end
        ADDR_TEST_MODE: begin
          st_nxt.regs.test_mode_select = word_committed;
        end
        ADDR_UNUSED: begin
          st_nxt.regs = st_r.regs;
        end
      endcase
    end

    // Applied power-control bit only moves at the start of a transmit slot
    if (receive_select_input_fall) begin
      st_nxt.tpc_applied = st_r.regs.pll_configuration[POS_POWER_CTRL];
    end

    // Set wins over the receive-select clear
    if (pin_s.receive_select) begin
      st_nxt.lockout = 1'b0;
    end
    if (st_r.regs.pll_configuration[POS_UV_LOCKOUT] && pin_s.low_supply) begin
      st_nxt.lockout = 1'b1;
    end

    // Lockout only acts while its enable bit stays set
    st_nxt.amp_en = AMP_REQUEST_IN &
      ~(st_nxt.lockout & st_r.regs.pll_configuration[POS_UV_LOCKOUT]);

    if (st_r.regs.pll_configuration[POS_RF_BUF_MODE]) begin
      st_nxt.rf_buf_on = ~pin_s.receive_select & st_nxt.amp_en;
    end else begin
      st_nxt.rf_buf_on = ~pin_s.receive_select;
    end

    st_nxt.carrier_only = st_r.regs.pll_configuration[POS_CARRIER_ONLY] &
      ~pin_s.receive_select;

    // Driving means pulling low; the data role releases the pin
    st_nxt.pin_drive = ~st_r.regs.pll_configuration[POS_ANALOG_ROLE] &
      st_nxt.tpc_applied;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_r.regs.pll_configuration <= REG_RESET;
      st_r.regs.channel_divide_ratio <= REG_RESET;
      st_r.regs.test_mode_select <= REG_RESET;
      st_r.shift <= SHIFT_RESET;
      st_r.en_q <= 1'b0;
      st_r.clk_q <= 1'b0;
      st_r.receive_select_input_q <= 1'b0;
      st_r.tpc_applied <= 1'b0;
      st_r.lockout <= 1'b0;
      st_r.amp_en <= 1'b0;
      st_r.rf_buf_on <= 1'b0;
      st_r.carrier_only <= 1'b0;
      st_r.pin_drive <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign AMP_ENABLE_OUT = st_r.amp_en;
  assign RF_BUFFER_ON_OUT = st_r.rf_buf_on;
  assign CARRIER_ONLY_OUT = st_r.carrier_only;

  // Open drain: the driven level is always low
  assign POWER_CONTROL_PIN_OUT = 1'b0;
  assign POWER_CONTROL_PIN_OE_N_OUT = ~st_r.pin_drive;

  assign PUMP_SOURCES_OUT = st_r.regs.pll_configuration[POS_PUMP_POLARITY];
  assign REF_DIVIDE_RATIO_OUT = st_r.regs.pll_configuration[POS_REF_DIVIDE] ?
    REF_DIV_HIGH : REF_DIV_LOW;
  assign ANALOG_PIN_DATA_ROLE_OUT = st_r.regs.pll_configuration[POS_ANALOG_ROLE];
  assign STRENGTH_CLIP_ENABLE_OUT =
    ~st_r.regs.pll_configuration[POS_CLIP_DISABLE];
  assign RF_BUFFER_TIMING_MODE_OUT = st_r.regs.pll_configuration[POS_RF_BUF_MODE];
  assign CHANNEL_DIVIDE_VALUE_OUT =
    st_r.regs.channel_divide_ratio[POS_CHAN_LSB +: CHAN_W];
  assign DIGITAL_TEST_SELECTOR_OUT =
    st_r.regs.test_mode_select[POS_DIGITAL_TEST_LSB +: SEL_W];
  assign ANALOG_TEST_SELECTOR_OUT =
    st_r.regs.test_mode_select[POS_ANALOG_TEST_LSB +: SEL_W];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RESET_IN);

  shift_in_a: assert property (
    (clk_rise && !pin_s.ser_en) |=>
      st_r.shift == {$past(st_r.shift[WORD_W-2:0]), $past(pin_s.ser_data)})
    else $error("serial bit not shifted in");

  shift_hold_a: assert property (
    (pin_s.ser_en && st_r.en_q) |=> $stable(st_r.shift))
    else $error("shift register moved while enable high");

  pll_load_a: assert property (
    (en_rise && word_addr == ADDR_PLL_CFG) |=>
      st_r.regs.pll_configuration == $past(st_r.shift) &&
      $stable(st_r.regs.channel_divide_ratio) &&
      $stable(st_r.regs.test_mode_select))
    else $error("PLL configuration load wrong");

  chan_load_a: assert property (
    (en_rise && word_addr == ADDR_CHAN_DIV) |=>
      CHANNEL_DIVIDE_VALUE_OUT == $past(st_r.shift[POS_CHAN_LSB +: CHAN_W]) &&
      $stable(st_r.regs.pll_configuration))
    else $error("channel divide load wrong");

  test_load_a: assert property (
    (en_rise && word_addr == ADDR_TEST_MODE) |=>
      DIGITAL_TEST_SELECTOR_OUT == $past(st_r.shift[7:5]) &&
      ANALOG_TEST_SELECTOR_OUT == $past(st_r.shift[4:2]))
    else $error("test mode load wrong");

  unused_addr_a: assert property (
    (en_rise && word_addr == ADDR_UNUSED) |=> $stable(st_r.regs))
    else $error("address 11 changed a register");

  no_enable_rise_a: assert property (
    !en_rise |=> $stable(st_r.regs))
    else $error("register changed without enable rise");

  power_up_zero_a: assert property (
    $fell(RESET_IN) |-> st_r.regs == '0 && POWER_CONTROL_PIN_OE_N_OUT)
    else $error("registers not zero after power-up");

  tpc_hold_a: assert property (
    !receive_select_input_fall |=> st_r.tpc_applied == $past(st_r.tpc_applied))
    else $error("power control changed outside receive fall");

  tpc_take_a: assert property (
    receive_select_input_fall |=> st_r.tpc_applied ==
      $past(st_r.regs.pll_configuration[POS_POWER_CTRL]))
    else $error("power control not adopted at receive fall");

  pin_drive_a: assert property (
    ##1 (!POWER_CONTROL_PIN_OE_N_OUT) ==
      ($past(~st_r.regs.pll_configuration[POS_ANALOG_ROLE]) && st_r.tpc_applied))
    else $error("power control pin drive wrong");

  lockout_a: assert property (
    (st_r.regs.pll_configuration[POS_UV_LOCKOUT] && pin_s.low_supply) |=>
      st_r.lockout && !AMP_ENABLE_OUT)
    else $error("lockout did not force amplifier off");

  lockout_clear_a: assert property (
    (pin_s.receive_select && !pin_s.low_supply) |=> !st_r.lockout)
    else $error("lockout not cleared by receive select");

  ref_divide_a: assert property (
    REF_DIVIDE_RATIO_OUT == (st_r.regs.pll_configuration[POS_REF_DIVIDE] ?
      5'h12 : 5'h09))
    else $error("reference divide ratio wrong");

  carrier_only_a: assert property (
    ##1 CARRIER_ONLY_OUT == ($past(st_r.regs.pll_configuration[POS_CARRIER_ONLY]) &&
      !$past(pin_s.receive_select)))
    else $error("carrier-only output wrong");

  rf_buffer_a: assert property (
    (!st_r.regs.pll_configuration[POS_RF_BUF_MODE] && !pin_s.receive_select) |=>
      RF_BUFFER_ON_OUT)
    else $error("RF buffer off during transmit");

  rf_follow_a: assert property (
    (st_r.regs.pll_configuration[POS_RF_BUF_MODE] && !pin_s.receive_select) |=>
      RF_BUFFER_ON_OUT == AMP_ENABLE_OUT)
    else $error("RF buffer does not follow amplifier enable");

  rf_receive_off_a: assert property (
    pin_s.receive_select |=> !RF_BUFFER_ON_OUT)
    else $error("RF buffer on during receive");

  pump_load_a: assert property (
    (en_rise && word_addr == ADDR_PLL_CFG) |=>
      PUMP_SOURCES_OUT == $past(st_r.shift[POS_PUMP_POLARITY]))
    else $error("pump polarity not loaded");

  role_load_a: assert property (
    (en_rise && word_addr == ADDR_PLL_CFG) |=>
      ANALOG_PIN_DATA_ROLE_OUT == $past(st_r.shift[POS_ANALOG_ROLE]))
    else $error("analog pin role not loaded");

  clip_load_a: assert property (
    (en_rise && word_addr == ADDR_PLL_CFG) |=>
      STRENGTH_CLIP_ENABLE_OUT == !$past(st_r.shift[POS_CLIP_DISABLE]))
    else $error("strength clip enable not loaded");

  amp_free_a: assert property (
    !st_r.regs.pll_configuration[POS_UV_LOCKOUT] |=>
      AMP_ENABLE_OUT == $past(AMP_REQUEST_IN))
    else $error("amplifier enable disturbed with lockout off");

  lockout_hold_a: assert property (
    (st_r.lockout && !pin_s.receive_select) |=> st_r.lockout)
    else $error("lockout released while transmitting");

  role_release_a: assert property (
    st_r.regs.pll_configuration[POS_ANALOG_ROLE] |=> POWER_CONTROL_PIN_OE_N_OUT)
    else $error("power control pin driven in data role");

  shift_idle_a: assert property (
    !clk_rise |=> $stable(st_r.shift))
    else $error("shift register moved without serial clock rise");

endmodule // scr_bank

// File: hdl/scr_pkg.sv
// ****************************************************************
// Serial configuration register bank: shared constants and types
// ****************************************************************
package scr_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam int ADDR_W = 2;
  localparam int CHAN_W = 12;
  localparam int SEL_W = 3;
  localparam int DIV_W = 5;

  // Address codes in word bits 1..0
  localparam logic [1:0] ADDR_PLL_CFG = 2'h0;
  localparam logic [1:0] ADDR_CHAN_DIV = 2'h1;
  localparam logic [1:0] ADDR_TEST_MODE = 2'h2;
  localparam logic [1:0] ADDR_UNUSED = 2'h3;

  // Field positions, counted in word bits
  localparam int POS_DATA_LSB = 2;
  localparam int POS_PUMP_POLARITY = 2;
  localparam int POS_REF_DIVIDE = 3;
  localparam int POS_ANALOG_ROLE = 4;
  localparam int POS_CARRIER_ONLY = 6;
  localparam int POS_POWER_CTRL = 7;
  localparam int POS_RF_BUF_MODE = 8;
  localparam int POS_UV_LOCKOUT = 10;
  localparam int POS_CLIP_DISABLE = 11;
  localparam int POS_CHAN_LSB = 2;
  localparam int POS_ANALOG_TEST_LSB = 2;
  localparam int POS_DIGITAL_TEST_LSB = 5;

  // Reset values and reference divide ratios
  localparam logic [WORD_W-1:0] REG_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] SHIFT_RESET = 16'h0000;
  localparam logic [DIV_W-1:0] REF_DIV_LOW = 5'h09;
  localparam logic [DIV_W-1:0] REF_DIV_HIGH = 5'h12;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [WORD_W-1:0] pll_configuration;
    logic [WORD_W-1:0] channel_divide_ratio;
    logic [WORD_W-1:0] test_mode_select;
  } scr_regs_t;

  // Pins from outside the clock domain, in synchroniser order
  typedef struct packed {
    logic ser_en;
    logic ser_data;
    logic ser_clk;
    logic receive_select;
    logic low_supply;
  } scr_pins_t;

  typedef struct packed {
    scr_regs_t regs;
    logic [WORD_W-1:0] shift;
    logic en_q;
    logic clk_q;
    logic receive_select_input_q;
    logic tpc_applied;
    logic lockout;
    logic amp_en;
    logic rf_buf_on;
    logic carrier_only;
    logic pin_drive;
  } scr_state_t;

endpackage

// File: hdl/scr_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Two-flop synchroniser for a bundle of asynchronous levels
// ****************************************************************
module scr_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } scr_sync_state_t;

  scr_sync_state_t st_r;
  scr_sync_state_t st_nxt;

  if (WIDTH < 1) begin : g_width_check
    $error("scr_sync: WIDTH must be at least 1");
  end

  // Meta stage feeds only the stable stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule // scr_sync

// File: testbench/scr_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host controller on the three-wire serial bus
// ****************************************************************
module scr_host_model (
  // Pacing clock
  input wire logic mclk_in,
  // Three-wire bus
  output logic ser_en_out,
  output logic ser_data_out,
  output logic ser_clk_out
);
  // Half periods of 16 system cycles of 5 ns give the 160 ns serial clock
  localparam int HALF_CYC = 16;

  initial begin
    ser_en_out = 1'b1;
    ser_data_out = 1'b0;
    ser_clk_out = 1'b0;
  end

  task automatic half_bit();
    repeat (HALF_CYC) @(negedge mclk_in);
  endtask

  // Count may differ from 16 on purpose; serial clock idles low
  task automatic send_bits(input logic [31:0] bits, input int n);
    ser_en_out = 1'b0;
    half_bit();
    for (int i = n - 1; i >= 0; i--) begin
      ser_data_out = bits[i];
      half_bit();
      ser_clk_out = 1'b1;
      half_bit();
      ser_clk_out = 1'b0;
    end
    half_bit();
    ser_en_out = 1'b1;
    // Released line must not keep looking like the last bit
    ser_data_out = ~ser_data_out;
    half_bit();
  endtask

  // Clock pulses while enable stays high
  task automatic pulse_idle(input logic [7:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      ser_data_out = bits[i];
      half_bit();
      ser_clk_out = 1'b1;
      half_bit();
      ser_clk_out = 1'b0;
    end
  endtask
endmodule // scr_host_model

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import scr_pkg::*;
();
  logic mclk;
  logic reset;
  logic rx_sel;
  logic low_sup;
  logic amp_req;
  wire logic ser_en, ser_data, ser_clk, pc_pin;
  logic amp_en, rf_on, carrier, pc_out, pc_oe_n, pump, role, clip, buf_mode;
  logic [DIV_W-1:0] ref_div;
  logic [CHAN_W-1:0] chan;
  logic [SEL_W-1:0] digital_test_selector, analog_test_selector;
  logic [15:0] e_pll, e_chan, e_test;
  int miscompares;
  int n_tests;

  // Open-drain pin with pull-up
  assign pc_pin = pc_oe_n ? 1'b1 : pc_out;

  scr_host_model host (.mclk_in(mclk), .ser_en_out(ser_en), .ser_data_out(ser_data),
    .ser_clk_out(ser_clk));

  scr_bank dut (
    .MCLK_IN(mclk), .RESET_IN(reset), .SER_EN_IN(ser_en), .SER_DATA_IN(ser_data),
    .SER_CLK_IN(ser_clk), .RECEIVE_SELECT_IN(rx_sel), .LOW_SUPPLY_IN(low_sup),
    .AMP_REQUEST_IN(amp_req), .AMP_ENABLE_OUT(amp_en), .RF_BUFFER_ON_OUT(rf_on),
    .CARRIER_ONLY_OUT(carrier), .POWER_CONTROL_PIN_IN(pc_pin),
    .POWER_CONTROL_PIN_OUT(pc_out), .POWER_CONTROL_PIN_OE_N_OUT(pc_oe_n),
    .PUMP_SOURCES_OUT(pump), .REF_DIVIDE_RATIO_OUT(ref_div),
    .ANALOG_PIN_DATA_ROLE_OUT(role), .STRENGTH_CLIP_ENABLE_OUT(clip),
    .RF_BUFFER_TIMING_MODE_OUT(buf_mode), .CHANNEL_DIVIDE_VALUE_OUT(chan),
    .DIGITAL_TEST_SELECTOR_OUT(digital_test_selector), .ANALOG_TEST_SELECTOR_OUT(analog_test_selector));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    chk(16'(pump), 16'(e_pll[2]));
    chk(16'(ref_div), e_pll[3] ? 16'h0012 : 16'h0009);
    chk(16'(role), 16'(e_pll[4]));
    chk(16'(buf_mode), 16'(e_pll[8]));
    chk(16'(clip), {15'h0000, ~e_pll[11]});
    chk(16'(chan), 16'(e_chan[13:2]));
    chk(16'(digital_test_selector), 16'(e_test[7:5]));
    chk(16'(analog_test_selector), 16'(e_test[4:2]));
  endtask

  // Commit takes about three cycles after enable rises; eight leaves margin
  task automatic wr(input logic [15:0] w);
    host.send_bits({16'h0000, w}, 16);
    cyc(8);
    case (w[1:0])
      ADDR_PLL_CFG: e_pll = w;
      ADDR_CHAN_DIV: e_chan = w;
      ADDR_TEST_MODE: e_test = w;
      default: e_pll = e_pll;
    endcase
  endtask

  task automatic rx(input logic v);
    rx_sel = v;
    cyc(8);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check_all();
    chk(16'(pc_oe_n), 16'h0001);
    chk(16'(carrier), 16'h0000);
    chk(16'(amp_en), 16'h0000);
    chk(16'(rf_on), 16'h0000);
  endtask

  task automatic t_fields();
    logic [15:0] words [6] = '{16'h091C, 16'h3FFD, 16'h00AE, 16'hFFFF, 16'h24D5, 16'h0000};
    foreach (words[i]) begin
      wr(words[i]);
      check_all();
    end
  endtask

  task automatic t_shift();
    host.send_bits({12'h000, 4'hF, 16'h0011}, 20);
    cyc(8);
    e_chan = 16'h0011;
    check_all();
    // Had these been shifted, the word would land as channel 0x011
    host.pulse_idle(8'h01, 2);
    host.send_bits(32'h0000_0000, 0);
    cyc(8);
    check_all();
  endtask

  task automatic t_power_pin();
    wr(16'h0080);
    chk(16'(pc_oe_n), 16'h0001);
    rx(1'b0);
    chk(16'(pc_oe_n), 16'h0000);
    chk(16'(pc_pin), 16'h0000);
    wr(16'h0090);
    chk(16'(pc_oe_n), 16'h0001);
    wr(16'h0000);
    chk(16'(pc_oe_n), 16'h0000);
    rx(1'b1);
    rx(1'b0);
    chk(16'(pc_oe_n), 16'h0001);
    chk(16'(pc_out), 16'h0000);
    chk(16'(pc_pin), 16'h0001);
  endtask

  task automatic t_carrier();
    wr(16'h0040);
    chk(16'(carrier), 16'h0001);
    chk(16'(rf_on), 16'h0001);
    rx(1'b1);
    chk(16'(carrier), 16'h0000);
    chk(16'(rf_on), 16'h0000);
  endtask

  task automatic t_lockout();
    amp_req = 1'b1;
    rx(1'b0);
    low_sup = 1'b1;
    cyc(8);
    chk(16'(amp_en), 16'h0001);
    low_sup = 1'b0;
    wr(16'h0400);
    chk(16'(amp_en), 16'h0001);
    low_sup = 1'b1;
    cyc(8);
    chk(16'(amp_en), 16'h0000);
    low_sup = 1'b0;
    cyc(8);
    chk(16'(amp_en), 16'h0000);
    rx(1'b1);
    chk(16'(amp_en), 16'h0001);
    // Buffer now tracks the amplifier enable in transmit
    wr(16'h0100);
    rx(1'b0);
    chk(16'(rf_on), 16'h0001);
    amp_req = 1'b0;
    cyc(8);
    chk(16'(rf_on), 16'h0000);
  endtask

  task automatic test_done();
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    reset = 1'b1;
    rx_sel = 1'b1;
    low_sup = 1'b0;
    amp_req = 1'b0;
    e_pll = 16'h0000;
    e_chan = 16'h0000;
    e_test = 16'h0000;
    miscompares = 0;
    n_tests = 0;
    cyc(8);
    reset = 1'b0;
    cyc(4);
    t_reset();
    t_fields();
    t_shift();
    t_power_pin();
    t_carrier();
    t_lockout();
    test_done();
  end

  // About 15 frames of 600 cycles are expected; twice that is a hang
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    test_done();
  end
endmodule // tb_top
